// *** bench/cfe_fec_asserts.sv ***
// port checker for the front end control block
// assumes rising aclk and synchronous active low aresetn
`timescale 1ns/1ps
`include "cfe_defs.vh"

module cfe_fec_asserts #(
	parameter PW = 24,
	parameter AW = 16
) (
	// clock, reset, bus
	input wire          aclk,
	input wire          aresetn,
	input wire          s_axi_bvalid,
	// detector and calibration
	input wire          ref_diff_low,
	input wire          ref_pos_open,
	input wire          ref_neg_open,
	input wire          prim_cal_done,
	// settings and status
	input wire [2:0]    prim_range_code,
	input wire [21:0]   prim_fs_uv,
	input wire          prim_ext_ref_select,
	input wire [21:0]   aux_fs_uv,
	input wire          aux_ext_ref_select,
	input wire [1:0]    excitation_out_one,
	input wire [1:0]    excitation_out_two,
	input wire [2:0]    conv_mode_field,
	input wire [PW-1:0] prim_offset_coef,
	input wire [PW-1:0] prim_gain_coef,
	input wire          reference_missing_flag
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire fault = ref_diff_low | ref_pos_open | ref_neg_open;

	range_by_write_a: assert property (
		$changed(prim_range_code) |-> $rose(s_axi_bvalid)) else $error("range moved without a write");
	prim_scale_a: assert property (
		$past(aresetn) && $stable(prim_range_code) && $stable(prim_ext_ref_select)
		|-> prim_fs_uv == ((`CFE_FS_MIN_UV << prim_range_code) >> !prim_ext_ref_select)) else $error("primary scale");
	aux_scale_a: assert property (
		$past(aresetn) && $stable(aux_ext_ref_select)
		|-> aux_fs_uv == (aux_ext_ref_select ? `CFE_EXT_REF_UV : `CFE_INT_REF_UV)) else $error("aux scale");
	exc_routing_a: assert property (
		{excitation_out_one, excitation_out_two} inside {4'h0, 4'h5, 4'h8, 4'h2}) else $error("bad routing");
	flag_sets_a: assert property (
		fault [*8] |-> reference_missing_flag) else $error("flag not set");
	flag_clears_a: assert property (
		!fault [*8] |-> !reference_missing_flag) else $error("flag not cleared");
	cal_blocked_a: assert property (
		reference_missing_flag && prim_cal_done |=> $stable(prim_gain_coef) && $stable(prim_offset_coef))
		else $error("coef loaded");
	coef_cause_a: assert property (
		$changed(prim_gain_coef) |-> $past(prim_cal_done)
		|| ($rose(s_axi_bvalid) && $past(conv_mode_field) == 3'h0)) else $error("coef changed");
endmodule // cfe_fec_asserts

bind cfe_front_end_ctrl cfe_fec_asserts #(.PW(PW), .AW(AW)) i_cfe_fec_asserts (.*);

// *** bench/cfe_ref_source.sv ***
// reference source model driving the three reference detector pins
// assumes the bench picks a fault kind, zero meaning a healthy reference
`timescale 1ns/1ps

module cfe_ref_source (
	// clock and command
	input  wire       aclk,
	input  wire [1:0] fault_kind,
	// detector pins
	output reg        ref_diff_low = 1'b0,
	output reg        ref_pos_open = 1'b0,
	output reg        ref_neg_open = 1'b0
);
	// pins move only on clock edges so the detector never sees a glitch
	always @(posedge aclk) begin
		ref_diff_low <= (fault_kind == 2'h1);
		ref_pos_open <= (fault_kind == 2'h2);
		ref_neg_open <= (fault_kind == 2'h3);
	end
endmodule // cfe_ref_source

// *** bench/tb_top.sv ***
// self-checking bench for the front end control block over axi4-lite
// assumes the reference source model and the bound port checker
`timescale 1ns/1ps
`include "cfe_defs.vh"

module tb_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic        arready, rvalid, smp_v, cal_v, rd_low, rd_pos, rd_neg, flag, irq, burn;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, fault, exc_one, exc_two;
	logic [3:0]  wstrb;
	logic [23:0] smp_d, cal_d, gain;
	logic [21:0] fs_p, fs_a;
	logic [2:0]  mode;
	int          n_errors, checked, i;
	logic [23:0] sraw [6] = '{24'h0, 24'h7fffff, 24'h800000, 24'h0, 24'h400000, 24'h7fffff};
	logic [23:0] sexp [6] = '{24'h800000, 24'hffffff, 24'h0, 24'h0, 24'h800000, 24'hffffff};
	logic [3:0]  exc  [4] = '{4'h0, 4'h5, 4'h8, 4'h2};

	cfe_ref_source i_cfe_ref_source (.aclk(aclk), .fault_kind(fault), .ref_diff_low(rd_low),
		.ref_pos_open(rd_pos), .ref_neg_open(rd_neg));
	cfe_front_end_ctrl i_cfe_front_end_ctrl (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ref_diff_low(rd_low), .ref_pos_open(rd_pos), .ref_neg_open(rd_neg),
		.prim_sample_valid(smp_v), .prim_sample(smp_d), .aux_sample_valid(smp_v), .aux_sample(smp_d[23:8]),
		.prim_cal_done(cal_v), .prim_cal_value(cal_d), .aux_cal_done(cal_v), .aux_cal_value(cal_d[15:0]),
		.prim_range_code(), .prim_fs_uv(fs_p), .prim_unipolar(), .prim_ext_ref_select(), .aux_fs_uv(fs_a),
		.aux_unipolar(), .aux_ext_ref_select(), .burnout_enable(burn), .excitation_out_one(exc_one),
		.excitation_out_two(exc_two), .conv_mode_field(mode), .prim_conv_enable(), .aux_conv_enable(),
		.prim_offset_coef(), .prim_gain_coef(gain), .aux_offset_coef(), .aux_gain_coef(),
		.reference_missing_flag(flag), .irq(irq));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic guard(input int n);
		if (n >= 40) begin
			n_errors++;
			$display("wrong value at %0t: no answer", $time);
			finish_test();
		end
	endtask
	// bready and rready drop at the answer edge, then one edge passes before the next request
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			{awvalid, wvalid} <= {awvalid & ~awready, wvalid & ~wready};
			if (bvalid) break;
		end
		guard(n);
		bready <= 1'b0;
		chk(bresp, er, "bresp");
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		{araddr, arvalid, rready} <= {a, 2'h3};
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			arvalid <= arvalid & ~arready;
			if (rvalid) break;
		end
		guard(n);
		rready <= 1'b0;
		chk(rdata, exp, "rdata");
		chk(rresp, er, "rresp");
		@(posedge aclk);
	endtask
	// one filter pulse: a sample when s is high, a calibration result otherwise
	task automatic pulse(input logic s, input logic [23:0] d);
		{smp_v, smp_d, cal_v, cal_d} <= {s, d, ~s, d};
		@(posedge aclk);
		{smp_v, cal_v} <= 2'h0;
		cyc(2);
	endtask

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, smp_v, cal_v} = 8'h0;
		{awaddr, araddr, wdata, smp_d, cal_d, fault} = '0;
		wstrb = 4'hf;
		n_errors = 0;
		checked = 0;
		cyc(2);
		aresetn <= 1'b1;
		cyc(1);
		rd(`CFE_OFF_PRIM_OFS, 32'h800000, 2'h0);
		for (i = 0; i < 8; i++) begin
			wr(`CFE_OFF_PRIM_CTRL, 32'h10 | i, 2'h0);
			chk(fs_p, 32'h4e20 << i, "range");
		end
		wr(`CFE_OFF_PRIM_CTRL, 32'h7, 2'h0);
		chk(fs_p, 32'h138800, "half range");
		wr(`CFE_OFF_AUX_CTRL, 32'h1f, 2'h0);
		chk(fs_a, 32'h2625a0, "aux range");
		rd(`CFE_OFF_AUX_CTRL, 32'h18, 2'h0);
		wr(`CFE_OFF_AUX_CTRL, 32'h0, 2'h0);
		chk(fs_a, 32'h1312d0, "aux half");
		wr(`CFE_OFF_CUR_CTRL, 32'h1, 2'h0);
		chk(burn, 32'h1, "burnout");
		for (i = 0; i < 4; i++) begin
			wr(`CFE_OFF_CUR_CTRL, i << 1, 2'h0);
			chk({exc_one, exc_two, burn}, {exc[i], 1'b0}, "currents");
		end
		$display("test settings done");
		wr(`CFE_OFF_MODE, 32'h30, 2'h0);
		for (i = 0; i < 6; i++) begin
			wr(`CFE_OFF_PRIM_CTRL, (i > 2) ? 32'h1b : 32'h13, 2'h0);
			wr(`CFE_OFF_AUX_CTRL, (i > 2) ? 32'h8 : 32'h0, 2'h0);
			pulse(1'b1, sraw[i]);
			rd(`CFE_OFF_PRIM_DATA, sexp[i], 2'h0);
			rd(`CFE_OFF_AUX_DATA, sexp[i][23:8], 2'h0);
		end
		wr(`CFE_OFF_STATUS, 32'hf, 2'h0);
		wr(`CFE_OFF_IRQ_MASK, 32'h1, 2'h0);
		pulse(1'b1, 24'h0);
		chk(irq, 32'h1, "irq on");
		wr(`CFE_OFF_STATUS, 32'h1, 2'h0);
		chk(irq, 32'h0, "irq cleared");
		wr(`CFE_OFF_IRQ_MASK, 32'h0, 2'h0);
		pulse(1'b1, 24'h0);
		chk(irq, 32'h0, "irq masked");
		rd(`CFE_OFF_STATUS, 32'h3, 2'h0);
		$display("test coding done");
		for (i = 1; i < 4; i++) begin
			fault <= i[1:0];
			cyc(8);
			chk(flag, 32'h1, "flag set");
			pulse(1'b1, 24'h0);
			rd(`CFE_OFF_PRIM_DATA, 32'hffffff, 2'h0);
			rd(`CFE_OFF_AUX_DATA, 32'hffff, 2'h0);
			fault <= 2'h0;
			cyc(8);
			chk(flag, 32'h0, "flag clear");
		end
		wr(`CFE_OFF_STATUS, 32'hf, 2'h0);
		fault <= 2'h1;
		cyc(8);
		wr(`CFE_OFF_MODE, 32'h15, 2'h0);
		pulse(1'b0, 24'h123456);
		chk({mode, gain}, 32'h555555, "cal blocked");
		rd(`CFE_OFF_STATUS, 32'h15, 2'h0);
		fault <= 2'h0;
		cyc(8);
		wr(`CFE_OFF_MODE, 32'h15, 2'h0);
		pulse(1'b0, 24'h123456);
		chk({mode, gain}, 32'h123456, "cal loaded");
		wr(`CFE_OFF_MODE, 32'h34, 2'h0);
		pulse(1'b0, 24'h654321);
		rd(`CFE_OFF_PRIM_OFS, 32'h654321, 2'h0);
		rd(`CFE_OFF_AUX_OFS, 32'h4321, 2'h0);
		rd(`CFE_OFF_STATUS, 32'h7, 2'h0);
		$display("test reference done");
		wr(`CFE_OFF_MODE, 32'h11, 2'h0);
		wr(`CFE_OFF_PRIM_OFS, 32'habcd, 2'h0);
		rd(`CFE_OFF_PRIM_OFS, 32'h654321, 2'h0);
		wr(`CFE_OFF_MODE, 32'h0, 2'h0);
		wr(`CFE_OFF_PRIM_OFS, 32'habcd, 2'h0);
		rd(`CFE_OFF_PRIM_OFS, 32'habcd, 2'h0);
		wr(8'h30, 32'h1, 2'h2);
		rd(8'h30, 32'h0, 2'h2);
		$display("test access done");
		finish_test();
	end
endmodule // tb_top

// *** rtl/cfe_code_format.v ***
// output code formatter for one converter: offset binary, straight binary, or forced all ones
// assumes the filter hands a two's complement word where +/- full scale spans the whole width
`timescale 1ns/1ps

module cfe_code_format #(
	parameter W = 24
) (
	// filter word and settings
	input  wire [W-1:0] raw_word,
	input  wire         unipolar,
	input  wire         force_ones,
	// formatted result
	output reg  [W-1:0] code
);

	always @* begin
		if (force_ones) begin
			code = {W{1'b1}};
		end else if (!unipolar) begin
			// offset binary: -fs all zeros, zero 100..0, +fs all ones
			code = {~raw_word[W-1], raw_word[W-2:0]};
		end else if (raw_word[W-1]) begin
			// below zero cannot be shown in straight binary, so clamp
			code = {W{1'b0}};
		end else begin
			// the low fill bit makes +fs reach all ones while midscale stays 100..0
			code = {raw_word[W-2:0], &raw_word[W-2:0]};
		end
	end

endmodule // cfe_code_format

// *** rtl/cfe_defs.vh ***
// register map, field positions, codes and reset values of the adc front end control block
// assumes a 32-bit axi4-lite register bus with byte addresses below 8'h40
`ifndef CFE_DEFS_VH
`define CFE_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CFE_OFF_PRIM_CTRL   8'h00
`define CFE_OFF_AUX_CTRL    8'h04
`define CFE_OFF_CUR_CTRL    8'h08
`define CFE_OFF_MODE        8'h0c
`define CFE_OFF_STATUS      8'h10
`define CFE_OFF_IRQ_MASK    8'h14
`define CFE_OFF_PRIM_DATA   8'h18
`define CFE_OFF_AUX_DATA    8'h1c
`define CFE_OFF_PRIM_OFS    8'h20
`define CFE_OFF_PRIM_GAIN   8'h24
`define CFE_OFF_AUX_OFS     8'h28
`define CFE_OFF_AUX_GAIN    8'h2c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFE_CTL_RANGE_LSB   0
`define CFE_CTL_RANGE_MSB   2
`define CFE_CTL_UNI_BIT     3
`define CFE_CTL_XREF_BIT    4
`define CFE_CUR_BURN_BIT    0
`define CFE_CUR_EXC_LSB     1
`define CFE_CUR_EXC_MSB     2
`define CFE_MODE_LSB        0
`define CFE_MODE_MSB        2
`define CFE_MODE_PEN_BIT    4
`define CFE_MODE_AEN_BIT    5
`define CFE_ST_PRIMARY_CONV_READY_BIT     0
`define CFE_ST_AUX_CONV_READY_BIT     1
`define CFE_ST_PRIMARY_CAL_ERROR_BIT     2
`define CFE_ST_AUX_CAL_ERROR_BIT     3
`define CFE_ST_NOREF_BIT    4

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define CFE_MD_IDLE         3'h0
`define CFE_EXC_OFF         2'h0
`define CFE_EXC_SPLIT       2'h1
`define CFE_EXC_BOTH_ONE    2'h2
`define CFE_EXC_BOTH_TWO    2'h3
`define CFE_AXI_OKAY        2'h0
`define CFE_AXI_SLVERR      2'h2

// ----------------------------------------------------------------
// full scale figures in microvolts and reset values
// ----------------------------------------------------------------
`define CFE_FS_MIN_UV       22'h004e20
`define CFE_EXT_REF_UV      22'h2625a0
`define CFE_INT_REF_UV      22'h1312d0
`define CFE_CTRL_RST        8'h00
`define CFE_CUR_RST         3'h0
`define CFE_PRIM_OFS_RST    24'h800000
`define CFE_PRIM_GAIN_RST   24'h555555
`define CFE_AUX_OFS_RST     16'h8000
`define CFE_AUX_GAIN_RST    16'h5555

`endif

// *** rtl/cfe_front_end_ctrl.v ***
// control and status of the primary and auxiliary converter front ends, with an axi4-lite slave
// assumes the filter supplies sample and calibration pulses on aclk, detector pins are asynchronous
`timescale 1ns/1ps
`include "cfe_defs.vh"

module cfe_front_end_ctrl #(
	parameter PW = 24,
	parameter AW = 16
) (
	// clock and reset
	input  wire          aclk,
	input  wire          aresetn,
	// axi4-lite slave
	input  wire [7:0]    s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output wire          s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output wire          s_axi_wready,
	output wire [1:0]    s_axi_bresp,
	output wire          s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [7:0]    s_axi_araddr,
	input  wire          s_axi_arvalid,
	output wire          s_axi_arready,
	output wire [31:0]   s_axi_rdata,
	output wire [1:0]    s_axi_rresp,
	output wire          s_axi_rvalid,
	input  wire          s_axi_rready,
	// reference detector pins
	input  wire          ref_diff_low,
	input  wire          ref_pos_open,
	input  wire          ref_neg_open,
	// filter and calibration engine
	input  wire          prim_sample_valid,
	input  wire [PW-1:0] prim_sample,
	input  wire          aux_sample_valid,
	input  wire [AW-1:0] aux_sample,
	input  wire          prim_cal_done,
	input  wire [PW-1:0] prim_cal_value,
	input  wire          aux_cal_done,
	input  wire [AW-1:0] aux_cal_value,
	// analog front end settings
	output wire [2:0]    prim_range_code,
	output wire [21:0]   prim_fs_uv,
	output wire          prim_unipolar,
	output wire          prim_ext_ref_select,
	output wire [21:0]   aux_fs_uv,
	output wire          aux_unipolar,
	output wire          aux_ext_ref_select,
	output wire          burnout_enable,
	output wire [1:0]    excitation_out_one,
	output wire [1:0]    excitation_out_two,
	output wire [2:0]    conv_mode_field,
	output wire          prim_conv_enable,
	output wire          aux_conv_enable,
	output wire [PW-1:0] prim_offset_coef,
	output wire [PW-1:0] prim_gain_coef,
	output wire [AW-1:0] aux_offset_coef,
	output wire [AW-1:0] aux_gain_coef,
	// status
	output wire          reference_missing_flag,
	output wire          irq
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function [31:0] merge_strb;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  strb;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				merge_strb[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
			end
		end
	endfunction

	function is_mapped;
		input [7:0] a;
		begin
			is_mapped = (a[1:0] == 2'h0) && (a <= `CFE_OFF_AUX_GAIN);
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg          awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	reg          aw_held_ff, w_held_ff;
	reg [7:0]    aw_addr_ff;
	reg [31:0]   w_data_ff;
	reg [3:0]    w_strb_ff;
	reg [1:0]    bresp_ff, rresp_ff;
	reg [31:0]   rdata_ff;
	reg [7:0]    prim_ctrl_ff, aux_ctrl_ff;
	reg [2:0]    cur_ctrl_ff;
	reg [2:0]    mode_ff;
	reg          pen_ff, aen_ff;
	reg [3:0]    stat_ff, mask_ff;
	reg [PW-1:0] prim_data_ff, prim_ofs_ff, prim_gain_ff;
	reg [AW-1:0] aux_data_ff, aux_ofs_ff, aux_gain_ff;
	reg          prim_pend_ff, aux_pend_ff, prim_bad_ff, aux_bad_ff;
	reg [2:0]    det_s1_ff, det_s2_ff, det_s3_ff, det_ff;
	reg          noref_ff, irq_ff;
	reg [21:0]   prim_fs_ff, aux_fs_ff;
	reg [1:0]    exc_one_ff, exc_two_ff;
	reg [31:0]   nxt_rdata;

	wire          do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
	wire          cal_mode = mode_ff[2];
	wire          wr_ok    = is_mapped(aw_addr_ff);
	wire [PW-1:0] prim_code;
	wire [AW-1:0] aux_code;

	// ----------------------------------------------------------------
	// reference detector: three stage sync, a bit moves once stages two and three agree
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			det_s1_ff <= 3'h0;
			det_s2_ff <= 3'h0;
			det_s3_ff <= 3'h0;
			det_ff    <= 3'h0;
			noref_ff  <= 1'b0;
		end else begin
			det_s1_ff <= {ref_neg_open, ref_pos_open, ref_diff_low};
			det_s2_ff <= det_s1_ff;
			det_s3_ff <= det_s2_ff;
			det_ff    <= (det_s2_ff & det_s3_ff) | (det_ff & (det_s2_ff | det_s3_ff));
			noref_ff  <= |det_ff;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite handshakes
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff  <= 32'h00000000;
			w_strb_ff  <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `CFE_AXI_OKAY;
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= `CFE_AXI_OKAY;
			rdata_ff   <= 32'h00000000;
		end else begin
			if (s_axi_awvalid && awready_ff) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
				awready_ff <= 1'b0;
			end
			if (s_axi_wvalid && wready_ff) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
				wready_ff <= 1'b0;
			end
			if (do_write) begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_ok ? `CFE_AXI_OKAY : `CFE_AXI_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				// address and data slots reopen only once the response is taken
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
			if (s_axi_arvalid && arready_ff) begin
				arready_ff <= 1'b0;
				rvalid_ff  <= 1'b1;
				rdata_ff   <= nxt_rdata;
				rresp_ff   <= is_mapped(s_axi_araddr) ? `CFE_AXI_OKAY : `CFE_AXI_SLVERR;
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff  <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	always @* begin
		nxt_rdata = 32'h00000000;
		case (s_axi_araddr)
			`CFE_OFF_PRIM_CTRL: nxt_rdata = {24'h000000, prim_ctrl_ff};
			`CFE_OFF_AUX_CTRL:  nxt_rdata = {24'h000000, aux_ctrl_ff};
			`CFE_OFF_CUR_CTRL:  nxt_rdata = {29'h00000000, cur_ctrl_ff};
			`CFE_OFF_MODE:      nxt_rdata = {26'h0000000, aen_ff, pen_ff, 1'b0, mode_ff};
			`CFE_OFF_STATUS:    nxt_rdata = {27'h0000000, noref_ff, stat_ff};
			`CFE_OFF_IRQ_MASK:  nxt_rdata = {28'h0000000, mask_ff};
			`CFE_OFF_PRIM_DATA: nxt_rdata = {{(32-PW){1'b0}}, prim_data_ff};
			`CFE_OFF_AUX_DATA:  nxt_rdata = {{(32-AW){1'b0}}, aux_data_ff};
			`CFE_OFF_PRIM_OFS:  nxt_rdata = {{(32-PW){1'b0}}, prim_ofs_ff};
			`CFE_OFF_PRIM_GAIN: nxt_rdata = {{(32-PW){1'b0}}, prim_gain_ff};
			`CFE_OFF_AUX_OFS:   nxt_rdata = {{(32-AW){1'b0}}, aux_ofs_ff};
			`CFE_OFF_AUX_GAIN:  nxt_rdata = {{(32-AW){1'b0}}, aux_gain_ff};
			default:            nxt_rdata = 32'h00000000;
		endcase
	end

	// ----------------------------------------------------------------
	// result coding
	// ----------------------------------------------------------------
	cfe_code_format #(.W(PW)) u_prim_fmt (
		.raw_word   (prim_sample),
		.unipolar   (prim_ctrl_ff[`CFE_CTL_UNI_BIT]),
		.force_ones (noref_ff),
		.code       (prim_code)
	);

	cfe_code_format #(.W(AW)) u_aux_fmt (
		.raw_word   (aux_sample),
		.unipolar   (aux_ctrl_ff[`CFE_CTL_UNI_BIT]),
		.force_ones (noref_ff),
		.code       (aux_code)
	);

	// ----------------------------------------------------------------
	// registers, calibration and status
	// ----------------------------------------------------------------
	wire [31:0] wv        = w_data_ff;
	wire        wr_mode   = do_write && (aw_addr_ff == `CFE_OFF_MODE) && w_strb_ff[0];
	wire        coef_open = (mode_ff == `CFE_MD_IDLE);
	wire        prim_cal  = cal_mode & prim_pend_ff;
	wire        aux_cal   = cal_mode & aux_pend_ff;
	wire        prim_fin  = prim_cal & prim_cal_done;
	wire        aux_fin   = aux_cal & aux_cal_done;
	wire        prim_fail = prim_bad_ff | noref_ff;
	wire        aux_fail  = aux_bad_ff | noref_ff;
	wire [3:0]  st_set    = {aux_fin & aux_fail, prim_fin & prim_fail,
	                         aux_fin | (aux_sample_valid & aen_ff & ~cal_mode),
	                         prim_fin | (prim_sample_valid & pen_ff & ~cal_mode)};
	wire [3:0]  st_clr    = (do_write && aw_addr_ff == `CFE_OFF_STATUS && w_strb_ff[0]) ? wv[3:0] : 4'h0;
	wire        prim_pend_nxt = prim_pend_ff & ~prim_fin;
	wire        aux_pend_nxt  = aux_pend_ff & ~aux_fin;
	wire [31:0] wm_pctl  = merge_strb({24'h000000, prim_ctrl_ff}, wv, w_strb_ff);
	wire [31:0] wm_actl  = merge_strb({24'h000000, aux_ctrl_ff}, wv, w_strb_ff);
	wire [31:0] wm_pofs  = merge_strb({{(32-PW){1'b0}}, prim_ofs_ff}, wv, w_strb_ff);
	wire [31:0] wm_pgain = merge_strb({{(32-PW){1'b0}}, prim_gain_ff}, wv, w_strb_ff);
	wire [31:0] wm_aofs  = merge_strb({{(32-AW){1'b0}}, aux_ofs_ff}, wv, w_strb_ff);
	wire [31:0] wm_again = merge_strb({{(32-AW){1'b0}}, aux_gain_ff}, wv, w_strb_ff);

	always @(posedge aclk) begin
		if (!aresetn) begin
			prim_ctrl_ff <= `CFE_CTRL_RST;
			aux_ctrl_ff  <= `CFE_CTRL_RST;
			cur_ctrl_ff  <= `CFE_CUR_RST;
			mode_ff      <= `CFE_MD_IDLE;
			pen_ff       <= 1'b0;
			aen_ff       <= 1'b0;
			stat_ff      <= 4'h0;
			mask_ff      <= 4'h0;
			prim_data_ff <= {PW{1'b0}};
			aux_data_ff  <= {AW{1'b0}};
			prim_ofs_ff  <= `CFE_PRIM_OFS_RST;
			prim_gain_ff <= `CFE_PRIM_GAIN_RST;
			aux_ofs_ff   <= `CFE_AUX_OFS_RST;
			aux_gain_ff  <= `CFE_AUX_GAIN_RST;
			prim_pend_ff <= 1'b0;
			aux_pend_ff  <= 1'b0;
			prim_bad_ff  <= 1'b0;
			aux_bad_ff   <= 1'b0;
			irq_ff       <= 1'b0;
		end else begin
			if (do_write && w_strb_ff[0]) begin
				case (aw_addr_ff)
					`CFE_OFF_PRIM_CTRL: prim_ctrl_ff <= wm_pctl[7:0] & 8'h1f;
					`CFE_OFF_AUX_CTRL:  aux_ctrl_ff  <= wm_actl[7:0] & 8'h18;
					`CFE_OFF_CUR_CTRL:  cur_ctrl_ff  <= wv[2:0];
					`CFE_OFF_IRQ_MASK:  mask_ff      <= wv[3:0];
					default: ;
				endcase
			end
			// coefficient writes from software only while the mode field is idle
			if (do_write && coef_open) begin
				case (aw_addr_ff)
					`CFE_OFF_PRIM_OFS:  prim_ofs_ff  <= wm_pofs[PW-1:0];
					`CFE_OFF_PRIM_GAIN: prim_gain_ff <= wm_pgain[PW-1:0];
					`CFE_OFF_AUX_OFS:   aux_ofs_ff   <= wm_aofs[AW-1:0];
					`CFE_OFF_AUX_GAIN:  aux_gain_ff  <= wm_again[AW-1:0];
					default: ;
				endcase
			end
			// a mode write restarts calibration tracking from a clean slate
			if (wr_mode) begin
				mode_ff      <= wv[`CFE_MODE_MSB:`CFE_MODE_LSB];
				pen_ff       <= wv[`CFE_MODE_PEN_BIT];
				aen_ff       <= wv[`CFE_MODE_AEN_BIT];
				prim_pend_ff <= wv[2] & wv[`CFE_MODE_PEN_BIT];
				aux_pend_ff  <= wv[2] & wv[`CFE_MODE_AEN_BIT];
				prim_bad_ff  <= 1'b0;
				aux_bad_ff   <= 1'b0;
			end else begin
				prim_pend_ff <= prim_pend_nxt;
				aux_pend_ff  <= aux_pend_nxt;
				prim_bad_ff  <= prim_bad_ff | (prim_cal & noref_ff);
				aux_bad_ff   <= aux_bad_ff | (aux_cal & noref_ff);
				if (cal_mode && !prim_pend_nxt && !aux_pend_nxt) begin
					mode_ff <= `CFE_MD_IDLE;
				end
			end
			// mode bit 0 clear means a zero-scale point, set means full scale
			if (prim_fin && !prim_fail) begin
				if (mode_ff[0]) begin
					prim_gain_ff <= prim_cal_value;
				end else begin
					prim_ofs_ff <= prim_cal_value;
				end
			end
			if (aux_fin && !aux_fail) begin
				if (mode_ff[0]) begin
					aux_gain_ff <= aux_cal_value;
				end else begin
					aux_ofs_ff <= aux_cal_value;
				end
			end
			if (prim_sample_valid && pen_ff && !cal_mode) begin
				prim_data_ff <= prim_code;
			end
			if (aux_sample_valid && aen_ff && !cal_mode) begin
				aux_data_ff <= aux_code;
			end
			// set wins over a same-cycle write-one-to-clear
			stat_ff <= (stat_ff & ~st_clr) | st_set;
			irq_ff  <= |(((stat_ff & ~st_clr) | st_set) & mask_ff);
		end
	end

	// ----------------------------------------------------------------
	// analog settings
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			prim_fs_ff <= 22'h000000;
			aux_fs_ff  <= 22'h000000;
			exc_one_ff <= 2'h0;
			exc_two_ff <= 2'h0;
		end else begin
			prim_fs_ff <= (`CFE_FS_MIN_UV << prim_ctrl_ff[`CFE_CTL_RANGE_MSB:`CFE_CTL_RANGE_LSB])
			              >> (prim_ctrl_ff[`CFE_CTL_XREF_BIT] ? 1'b0 : 1'b1);
			aux_fs_ff  <= aux_ctrl_ff[`CFE_CTL_XREF_BIT] ? `CFE_EXT_REF_UV : `CFE_INT_REF_UV;
			case (cur_ctrl_ff[`CFE_CUR_EXC_MSB:`CFE_CUR_EXC_LSB])
				`CFE_EXC_SPLIT: begin
					exc_one_ff <= 2'h1;
					exc_two_ff <= 2'h1;
				end
				`CFE_EXC_BOTH_ONE: begin
					exc_one_ff <= 2'h2;
					exc_two_ff <= 2'h0;
				end
				`CFE_EXC_BOTH_TWO: begin
					exc_one_ff <= 2'h0;
					exc_two_ff <= 2'h2;
				end
				default: begin
					exc_one_ff <= 2'h0;
					exc_two_ff <= 2'h0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready          = awready_ff;
	assign s_axi_wready           = wready_ff;
	assign s_axi_bresp            = bresp_ff;
	assign s_axi_bvalid           = bvalid_ff;
	assign s_axi_arready          = arready_ff;
	assign s_axi_rdata            = rdata_ff;
	assign s_axi_rresp            = rresp_ff;
	assign s_axi_rvalid           = rvalid_ff;
	assign prim_range_code        = prim_ctrl_ff[`CFE_CTL_RANGE_MSB:`CFE_CTL_RANGE_LSB];
	assign prim_fs_uv             = prim_fs_ff;
	assign prim_unipolar          = prim_ctrl_ff[`CFE_CTL_UNI_BIT];
	assign prim_ext_ref_select    = prim_ctrl_ff[`CFE_CTL_XREF_BIT];
	assign aux_fs_uv              = aux_fs_ff;
	assign aux_unipolar           = aux_ctrl_ff[`CFE_CTL_UNI_BIT];
	assign aux_ext_ref_select     = aux_ctrl_ff[`CFE_CTL_XREF_BIT];
	assign burnout_enable         = cur_ctrl_ff[`CFE_CUR_BURN_BIT];
	assign excitation_out_one     = exc_one_ff;
	assign excitation_out_two     = exc_two_ff;
	assign conv_mode_field        = mode_ff;
	assign prim_conv_enable       = pen_ff;
	assign aux_conv_enable        = aen_ff;
	assign prim_offset_coef       = prim_ofs_ff;
	assign prim_gain_coef         = prim_gain_ff;
	assign aux_offset_coef        = aux_ofs_ff;
	assign aux_gain_coef          = aux_gain_ff;
	assign reference_missing_flag = noref_ff;
	assign irq                    = irq_ff;

endmodule // cfe_front_end_ctrl
